//--- logic/crtt_top.sv
// CAN receive buffer writer, receive timeout and transmit trigger timers behind APB
//
// Our own choices: register access over APB and the address map.
`include "crtt_map.svh"

module crtt_top
	import crtt_pkg::*;
#(
	parameter int NBUF = 4
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Received frames from the protocol engine
	input  wire logic        rx_valid,
	output logic             rx_ready,
	input  wire logic [1:0]  rx_target,
	input  wire logic [1:0]  rx_buf_idx,
	input  wire logic [3:0]  rx_dlc,
	input  wire logic [63:0] rx_payload,
	// External timer clock pin
	input  wire logic        ext_tick_in,
	// Requests and triggers
	output logic [2:0]       new_frame_req,
	output logic             rx_timeout_req,
	output logic [2:0]       tx_trigger
);
	localparam int DW = 2 + 2 + 4 + 64;
	localparam int MW = $clog2(NBUF * `CRTT_BYTES_PER_BUF);

	//--------------------------------------------------------------------------
	// Helpers
	//--------------------------------------------------------------------------
	// Classical frames carry at most eight bytes; larger DLC codes clamp
	function automatic logic [3:0] dlc_bytes(input logic [3:0] dlc);
		dlc_bytes = (dlc > 4'h8) ? 4'h8 : dlc;
	endfunction

	function automatic logic [MW-1:0] mem_addr(input logic [1:0] buf_i, input logic [2:0] byte_i);
		mem_addr = MW'({buf_i, byte_i});
	endfunction

	//--------------------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------------------
	logic [7:0]      buf_mem [NBUF * `CRTT_BYTES_PER_BUF];
	logic            f_valid;
	logic            f_ready;
	logic [DW-1:0]   f_data;
	crtt_wr_state_t  wr_state_q, wr_state_d;
	logic [DW-1:0]   frame_q, frame_d;
	logic [3:0]      byte_idx_q, byte_idx_d;
	logic            mem_we;
	logic            commit;
	logic [1:0]      fr_target;
	logic [1:0]      fr_buf;
	logic [3:0]      fr_dlc;
	logic [63:0]     fr_payload;

	logic [15:0]     presc_q, presc_d;
	crtt_clk_src_t   clk_src_q, clk_src_d;
	logic [2:0]      irq_en_q, irq_en_d;
	logic [2:0]      nf_flag_q, nf_flag_d;
	logic [2:0]      nf_set;
	logic [2:0]      nf_req_q;
	logic [15:0]     to_reload_q, to_reload_d;
	logic            timeout_irq_en_q, timeout_irq_en_d;
	logic            te_q, te_d;
	logic [15:0]     to_cnt_q, to_cnt_d;
	logic [15:0]     trig_reload_q [`CRTT_NUM_TRIG];
	logic [15:0]     trig_reload_d [`CRTT_NUM_TRIG];
	logic [2:0]      trig_load;
	logic [2:0]      trig_run;

	logic            ext_s1_q, ext_s2_q, ext_s3_q;
	logic [15:0]     div_q, div_d;
	logic            tick;
	logic            src_event;

	logic            wr_en;
	logic            setup;
	logic [31:0]     prdata_q, prdata_d;
	logic            perr_q, perr_d;
	logic            frame_hit;

	//--------------------------------------------------------------------------
	// Frame FIFO: back-pressure reaches the engine through rx_ready
	//--------------------------------------------------------------------------
	crtt_fifo #(
		.WIDTH (DW),
		.DEPTH (`CRTT_FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   ({rx_target, rx_buf_idx, rx_dlc, rx_payload}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	//--------------------------------------------------------------------------
	// Buffer writer: one byte per cycle, so the FIFO stalls while it works
	//--------------------------------------------------------------------------
	assign {fr_target, fr_buf, fr_dlc, fr_payload} = frame_q;
	assign f_ready = (wr_state_q == CRTT_WR_IDLE);

	// Only DLC bytes are written; untouched bytes keep what they held
	always_comb begin
		wr_state_d = wr_state_q;
		frame_d    = frame_q;
		byte_idx_d = byte_idx_q;
		mem_we     = 1'b0;
		commit     = 1'b0;
		case (wr_state_q)
			CRTT_WR_IDLE: begin
				if (f_valid) begin
					frame_d    = f_data;
					byte_idx_d = 4'h0;
					wr_state_d = CRTT_WR_BYTES;
				end
			end
			CRTT_WR_BYTES: begin
				if (byte_idx_q < dlc_bytes(fr_dlc)) begin
					mem_we     = 1'b1; // [R1]
					byte_idx_d = byte_idx_q + 4'h1;
				end else begin
					commit     = 1'b1;
					wr_state_d = CRTT_WR_IDLE;
				end
			end
			default: begin
				wr_state_d = CRTT_WR_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_state_q <= CRTT_WR_IDLE;
			frame_q    <= '0;
			byte_idx_q <= 4'h0;
		end else begin
			wr_state_q <= wr_state_d;
			frame_q    <= frame_d;
			byte_idx_q <= byte_idx_d;
		end
	end

	// Buffer RAM has no reset and is never cleared
	always_ff @(posedge pclk) begin
		if (mem_we) begin
			buf_mem[mem_addr(fr_buf, byte_idx_q[2:0])] <= fr_payload[byte_idx_q[2:0]*8 +: 8]; // [R1]
		end
	end

	//--------------------------------------------------------------------------
	// Timer tick: selected source divided by prescaler + 1
	//--------------------------------------------------------------------------
	// Pin passes three flops; the edge detector looks only at the second and third
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_tick_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	assign src_event = (clk_src_q == CRTT_SRC_PCLK) ? 1'b1 : (ext_s2_q && !ext_s3_q);
	assign tick      = src_event && (div_q >= presc_q); // [R6]

	always_comb begin
		div_d = div_q;
		if (src_event) begin
			div_d = (div_q >= presc_q) ? 16'h0000 : div_q + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_d;
		end
	end

	//--------------------------------------------------------------------------
	// Trigger timers share the tick
	//--------------------------------------------------------------------------
	for (genvar g = 0; g < `CRTT_NUM_TRIG; g++) begin : g_trig
		crtt_trig_timer #(
			.CW (16)
		) u_trig (
			.pclk       (pclk),
			.presetn    (presetn),
			.load       (trig_load[g]),
			.reload_val (pwdata[`CRTT_RELOAD_MSB:0]),
			.tick       (tick), // [R6]
			.running    (trig_run[g]),
			.trigger    (tx_trigger[g])
		);
	end

	//--------------------------------------------------------------------------
	// APB decode
	//--------------------------------------------------------------------------
	assign wr_en  = psel && penable && pwrite;
	assign setup  = psel && !penable;
	assign pready = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = perr_q && psel && penable;
	assign frame_hit = (paddr >= `CRTT_OFS_BUF_BASE) &&
		(paddr < (`CRTT_OFS_BUF_BASE + 12'(NBUF * `CRTT_BYTES_PER_BUF)));

	// Start only when the start bit rides on the same write as the reload
	always_comb begin
		trig_load[0] = wr_en && (paddr == `CRTT_OFS_TRIG_A) && pwdata[`CRTT_START_BIT]; // [R7]
		trig_load[1] = wr_en && (paddr == `CRTT_OFS_TRIG_B) && pwdata[`CRTT_START_BIT]; // [R7]
		trig_load[2] = wr_en && (paddr == `CRTT_OFS_TRIG_C) && pwdata[`CRTT_START_BIT]; // [R7]
	end

	// Read data is latched in the setup phase so prdata comes from a flop
	always_comb begin
		prdata_d = prdata_q;
		perr_d   = perr_q;
		if (setup) begin
			perr_d   = 1'b0;
			prdata_d = 32'h0000_0000;
			if (paddr == `CRTT_OFS_CLK_CTRL) begin
				prdata_d = {15'h0, clk_src_q, presc_q};
			end else if (paddr == `CRTT_OFS_IRQ_EN) begin
				prdata_d = {29'h0, irq_en_q};
			end else if (paddr == `CRTT_OFS_NF_FLAGS) begin
				prdata_d = {29'h0, nf_flag_q};
			end else if (paddr == `CRTT_OFS_RX_TIMEOUT) begin
				prdata_d = {te_q, 14'h0, timeout_irq_en_q, to_reload_q};
			end else if (paddr == `CRTT_OFS_TRIG_A) begin
				prdata_d = {1'b0, trig_run[0], 14'h0, trig_reload_q[0]};
			end else if (paddr == `CRTT_OFS_TRIG_B) begin
				prdata_d = {1'b0, trig_run[1], 14'h0, trig_reload_q[1]};
			end else if (paddr == `CRTT_OFS_TRIG_C) begin
				prdata_d = {1'b0, trig_run[2], 14'h0, trig_reload_q[2]};
			end else if (frame_hit && (paddr[1:0] == 2'h0)) begin
				prdata_d = {buf_mem[MW'(paddr[MW-1:0] + 3'h3)], buf_mem[MW'(paddr[MW-1:0] + 3'h2)],
					buf_mem[MW'(paddr[MW-1:0] + 3'h1)], buf_mem[paddr[MW-1:0]]};
			end else begin
				perr_d = 1'b1;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Control registers
	//--------------------------------------------------------------------------
	always_comb begin
		presc_d     = presc_q;
		clk_src_d   = clk_src_q;
		irq_en_d    = irq_en_q;
		to_reload_d = to_reload_q;
		timeout_irq_en_d      = timeout_irq_en_q;
		for (int i = 0; i < `CRTT_NUM_TRIG; i++) begin
			trig_reload_d[i] = trig_reload_q[i];
			if (trig_load[i]) begin
				trig_reload_d[i] = pwdata[`CRTT_RELOAD_MSB:0];
			end
		end
		if (wr_en && (paddr == `CRTT_OFS_CLK_CTRL)) begin
			presc_d   = pwdata[`CRTT_PRESC_MSB:0];
			clk_src_d = crtt_clk_src_t'(pwdata[`CRTT_CLKSRC_BIT]);
		end
		if (wr_en && (paddr == `CRTT_OFS_IRQ_EN)) begin
			irq_en_d = pwdata[2:0];
		end
		if (wr_en && (paddr == `CRTT_OFS_RX_TIMEOUT)) begin
			to_reload_d = pwdata[`CRTT_RELOAD_MSB:0];
			timeout_irq_en_d      = pwdata[`CRTT_TIMEOUT_IRQ_EN_BIT];
		end
	end

	//--------------------------------------------------------------------------
	// New-frame flags: hardware set beats a same-cycle write-one clear
	//--------------------------------------------------------------------------
	always_comb begin
		nf_set = 3'h0;
		if (commit) begin
			nf_set[fr_target] = 1'b1;
		end
		nf_flag_d = nf_flag_q;
		if (wr_en && (paddr == `CRTT_OFS_NF_FLAGS)) begin
			nf_flag_d = nf_flag_q & ~pwdata[2:0];
		end
		nf_flag_d = nf_flag_d | nf_set; // [R10]
	end

	//--------------------------------------------------------------------------
	// Receive timeout
	//--------------------------------------------------------------------------
	// Only a frame whose target enable is set restarts the count
	always_comb begin
		to_cnt_d = to_cnt_q;
		te_d     = te_q;
		if (wr_en && (paddr == `CRTT_OFS_RX_TIMEOUT)) begin
			to_cnt_d = pwdata[`CRTT_RELOAD_MSB:0];
		end else if (commit && irq_en_q[fr_target]) begin
			to_cnt_d = to_reload_q; // [R4]
		end else if ((to_reload_q != 16'h0000) && tick) begin // [R3]
			if (to_cnt_q == 16'h0000) begin
				to_cnt_d = to_reload_q;
				te_d     = 1'b1;
			end else begin
				to_cnt_d = to_cnt_q - 16'h0001;
			end
		end
		// This flag alone lets the clear win over a same-cycle set
		if (wr_en && (paddr == `CRTT_OFS_RX_TIMEOUT) && pwdata[`CRTT_TE_BIT]) begin
			te_d = 1'b0; // [R10]
		end
	end

	//--------------------------------------------------------------------------
	// State registers
	//--------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q     <= `CRTT_RST_PRESC;
			clk_src_q   <= CRTT_SRC_PCLK;
			irq_en_q    <= 3'h0;
			nf_flag_q   <= 3'h0;
			nf_req_q    <= 3'h0;
			to_reload_q <= `CRTT_RST_RELOAD;
			timeout_irq_en_q      <= 1'b0;
			te_q        <= 1'b0;
			to_cnt_q    <= `CRTT_RST_RELOAD;
			prdata_q    <= 32'h0000_0000;
			perr_q      <= 1'b0;
			for (int i = 0; i < `CRTT_NUM_TRIG; i++) begin
				trig_reload_q[i] <= `CRTT_RST_RELOAD;
			end
		end else begin
			presc_q     <= presc_d;
			clk_src_q   <= clk_src_d;
			irq_en_q    <= irq_en_d;
			nf_flag_q   <= nf_flag_d;
			nf_req_q    <= nf_flag_d & ~nf_flag_q & irq_en_q; // [R10]
			to_reload_q <= to_reload_d;
			timeout_irq_en_q      <= timeout_irq_en_d;
			te_q        <= te_d;
			to_cnt_q    <= to_cnt_d;
			prdata_q    <= prdata_d;
			perr_q      <= perr_d;
			for (int i = 0; i < `CRTT_NUM_TRIG; i++) begin
				trig_reload_q[i] <= trig_reload_d[i];
			end
		end
	end

	//--------------------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------------------
	assign new_frame_req  = nf_req_q;
	assign rx_timeout_req = te_q && timeout_irq_en_q; // [R11]

endmodule // crtt_top

//--- shared/crtt_map.svh
// Offsets, field positions, reset values and counts of the CAN receive and trigger block
//
// Function
// R1: A stored frame writes only its DLC's data bytes; other bytes keep their old value.
// R2: Software treats only the frame's DLC bytes as valid payload and ignores the rest.
// R3: The receive timeout runs while its reload field is non-zero and idles at zero.
// R4: A frame stored with its new-frame enable at 0 does not restart the timeout.
// R5: Software sets the new-frame enable of every storage target in use.
// R6: Three trigger timers each have a reload field and share one prescaled tick.
// R7: A trigger timer starts when one write sets its reload field and start bit.
// R8: A started trigger timer counts one more than its reload value, then fires.
// R9: Software programs a trigger reload one less than the count it wants.
// R10: A new-frame flag set beats a same-cycle clear; requests come only on 0 to 1.
// R11: The timeout request needs its enable; trigger timers step on prescaled ticks.
`ifndef CRTT_MAP_SVH
`define CRTT_MAP_SVH

//------------------------------------------------------------------------------
// Register offsets (byte addresses)
//------------------------------------------------------------------------------
`define CRTT_OFS_CLK_CTRL    12'h000
`define CRTT_OFS_IRQ_EN      12'h004
`define CRTT_OFS_NF_FLAGS    12'h008
`define CRTT_OFS_RX_TIMEOUT  12'h00C
`define CRTT_OFS_TRIG_A      12'h010
`define CRTT_OFS_TRIG_B      12'h014
`define CRTT_OFS_TRIG_C      12'h018
`define CRTT_OFS_BUF_BASE    12'h100

//------------------------------------------------------------------------------
// Field positions
//------------------------------------------------------------------------------
`define CRTT_PRESC_MSB       15
`define CRTT_CLKSRC_BIT      16
`define CRTT_RELOAD_MSB      15
`define CRTT_TIMEOUT_IRQ_EN_BIT        16
`define CRTT_TE_BIT          31
`define CRTT_START_BIT       31
`define CRTT_RUNNING_BIT     30

//------------------------------------------------------------------------------
// Sizes and reset values
//------------------------------------------------------------------------------
`define CRTT_BYTES_PER_BUF   8
`define CRTT_NUM_TRIG        3
`define CRTT_FIFO_DEPTH      8
`define CRTT_RST_PRESC       16'h0000
`define CRTT_RST_RELOAD      16'h0000

`endif

//--- shared/crtt_pkg.sv
// Types shared by the CAN receive and trigger block
package crtt_pkg;

	// Storage target of a received frame
	typedef enum logic [1:0] {
		CRTT_TGT_FIFO0 = 2'h0,
		CRTT_TGT_FIFO1 = 2'h1,
		CRTT_TGT_DED   = 2'h2
	} crtt_target_t;

	// Buffer writer states
	typedef enum logic {
		CRTT_WR_IDLE  = 1'b0,
		CRTT_WR_BYTES = 1'b1
	} crtt_wr_state_t;

	// Timer tick source
	typedef enum logic {
		CRTT_SRC_PCLK = 1'b0,
		CRTT_SRC_EXT  = 1'b1
	} crtt_clk_src_t;

endpackage

//--- logic/crtt_fifo.sv
// Frame descriptor FIFO between the receive engine and the buffer writer
module crtt_fifo #(
	parameter int WIDTH = 73,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
	logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
	logic [AW:0]      count_q, count_d;
	logic             push;
	logic             pop;

	//--------------------------------------------------------------------------
	// Handshakes
	//--------------------------------------------------------------------------
	assign in_ready  = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data  = mem[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer arithmetic; depth is a power of two so the pointers wrap freely
	always_comb begin
		wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
		rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
		count_d  = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
	end

	// Storage holds no reset: contents matter only once counted
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

endmodule // crtt_fifo

//--- logic/crtt_trig_timer.sv
// One transmit trigger timer: load with start, count down on ticks, fire at zero
module crtt_trig_timer #(
	parameter int CW = 16
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Control
	input  wire logic          load,
	input  wire logic [CW-1:0] reload_val,
	input  wire logic          tick,
	// Status
	output logic               running,
	output logic               trigger
);
	logic [CW-1:0] cnt_q, cnt_d;
	logic          run_q, run_d;
	logic          trig_q, trig_d;

	// Reaching zero takes reload ticks, firing takes one more, so reload+1 in all
	always_comb begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		trig_d = 1'b0;
		if (load) begin
			cnt_d = reload_val; // [R7]
			run_d = 1'b1;       // [R7]
		end else if (run_q && tick) begin
			if (cnt_q == '0) begin
				run_d  = 1'b0;
				trig_d = 1'b1; // [R8]
			end else begin
				cnt_d = cnt_q - 1'b1; // [R11]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			trig_q <= trig_d;
		end
	end

	assign running = run_q;
	assign trigger = trig_q;

endmodule // crtt_trig_timer

//--- sim/crtt_top_asserts.sv
// Port-level assertions for the CAN receive and trigger block
module crtt_top_asserts (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Requests
	input wire logic [2:0]  new_frame_req,
	input wire logic        rx_timeout_req,
	input wire logic [2:0]  tx_trigger
);
	timeunit 1ns;
	timeprecision 1ns;

	logic en_q;
	logic en_d;
	logic to_wr;

	// Shadow of the timeout enable, which no port shows
	assign to_wr = psel && penable && pwrite && paddr == 12'h00C;
	always_comb en_d = to_wr ? pwdata[16] : en_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'b0;
		end else begin
			en_q <= en_d;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------
	// Checks
	// ------------------------------
	AST_ERR_ONLY_ACCESS: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	AST_ERR_UNMAPPED: assert property (psel && penable && paddr == 12'h020 |-> pslverr)
		else $error("unmapped access not refused");
	AST_NO_ERR_MAPPED: assert property (psel && penable && paddr == 12'h004 |-> !pslverr)
		else $error("mapped access refused");
	AST_ERR_DATA_ZERO: assert property (psel && penable && pslverr |-> prdata == 32'h0)
		else $error("refused read data not zero");
	AST_NF_PULSE: assert property (
		new_frame_req != 3'h0 |=> (new_frame_req & $past(new_frame_req)) == 3'h0)
		else $error("new frame request longer than one cycle");
	AST_TRIG_PULSE: assert property (
		tx_trigger != 3'h0 |=> (tx_trigger & $past(tx_trigger)) == 3'h0)
		else $error("trigger longer than one cycle");
	AST_TO_NEEDS_EN: assert property (rx_timeout_req |-> en_q)
		else $error("timeout request without enable");
	AST_TO_CLEAR: assert property (to_wr && pwdata[31] |-> ##2 !rx_timeout_req)
		else $error("timeout request survives clear");

	// Main scenarios reached
	cover property (new_frame_req != 3'h0);
	cover property (tx_trigger != 3'h0);
	cover property (rx_timeout_req);
endmodule // crtt_top_asserts

bind crtt_top crtt_top_asserts chk_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
	.pwdata, .prdata, .pslverr, .new_frame_req, .rx_timeout_req, .tx_trigger);

//--- sim/crtt_can_node.sv
// Behavioural remote node that hands received frames to the block
module crtt_can_node (
	// Clock and reset
	input  wire logic   pclk,
	input  wire logic   presetn,
	// Frame descriptors
	output logic        rx_valid,
	input  wire logic   rx_ready,
	output logic [1:0]  rx_target,
	output logic [1:0]  rx_buf_idx,
	output logic [3:0]  rx_dlc,
	output logic [63:0] rx_payload,
	// Timer pin, parked low
	output logic        ext_tick_in
);
	timeunit 1ns;
	timeprecision 1ns;

	int stalls;

	// Idle lines; target 3 sets no new-frame flag
	initial begin
		stalls = 0;
		rx_valid = 1'b0;
		rx_target = 2'h3;
		rx_buf_idx = 2'h0;
		rx_dlc = 4'h0;
		rx_payload = 64'hA5A5_A5A5_A5A5_A5A5;
		ext_tick_in = 1'b0;
	end

	// Held until taken; released DLC and payload lines show the inverse
	task automatic send(input logic [1:0] tgt, input logic [1:0] idx, input logic [3:0] dlc,
			input logic [63:0] pay, input int gap);
		logic ok;
		int n;
		rx_valid <= 1'b1;
		rx_target <= tgt;
		rx_buf_idx <= idx;
		rx_dlc <= dlc;
		rx_payload <= pay;
		n = 0;
		do begin
			@(posedge pclk);
			ok = rx_ready;
			if (ok !== 1'b1) stalls++;
			n++;
		end while (ok !== 1'b1 && n < 400);
		if (ok !== 1'b1) tb.chk(32'h0, 32'h1, "frame taken");
		if (gap > 0) begin
			rx_valid <= 1'b0;
			rx_dlc <= ~dlc;
			rx_payload <= ~pay;
			repeat (gap) @(posedge pclk);
		end
	endtask
endmodule // crtt_can_node

//--- sim/tb.sv
// Self-checking bench for the CAN receive and trigger block
`include "crtt_map.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_valid;
	logic        rx_ready;
	logic [1:0]  rx_target;
	logic [1:0]  rx_buf_idx;
	logic [3:0]  rx_dlc;
	logic [63:0] rx_payload;
	logic        ext_tick_in;
	logic [2:0]  new_frame_req;
	logic        rx_timeout_req;
	logic [2:0]  tx_trigger;
	int          errors;
	int          tests_run;

	crtt_top #(.NBUF(4)) dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .rx_valid, .rx_ready, .rx_target, .rx_buf_idx, .rx_dlc,
		.rx_payload, .ext_tick_in, .new_frame_req, .rx_timeout_req, .tx_trigger);
	crtt_can_node can_u (.pclk, .presetn, .rx_valid, .rx_ready, .rx_target, .rx_buf_idx,
		.rx_dlc, .rx_payload, .ext_tick_in);

	// 20 MHz clock
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	// ------------------------------
	// Shared tasks
	// ------------------------------
	task automatic end_sim();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer, answer taken at the pready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		logic ok;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			ok = pready;
			r = prdata;
			e = pslverr;
			n++;
		end while (ok !== 1'b1 && n < 20);
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t no pready", $time);
			end_sim();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask

	// Cycles to a high request (0..2 trigger, 3 fifo0 frame, 4 timeout); 0 if none
	task automatic wait_sig(input int sel, input int lim, output int k);
		logic s;
		k = 0;
		do begin
			@(negedge pclk);
			s = sel < 3 ? tx_trigger[sel] : (sel == 3 ? new_frame_req[0] : rx_timeout_req);
			k++;
		end while (s !== 1'b1 && k < lim);
		if (s !== 1'b1) k = 0;
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		rd(`CRTT_OFS_CLK_CTRL, r);
		chk(r, 32'h0, "clock ctrl reset");
		rd(`CRTT_OFS_RX_TIMEOUT, r);
		chk(r, 32'h0, "timeout reset");
		wr(`CRTT_OFS_IRQ_EN, 32'h7);
		rd(`CRTT_OFS_IRQ_EN, r);
		chk(r & 32'h7, 32'h7, "irq enables");
		apb(1'b0, 12'h020, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1, "unmapped read");
		apb(1'b1, 12'h102, 32'h5, r, e);
		chk({31'h0, e}, 32'h1, "unaligned write");
	endtask

	// Long then short frame into one buffer: old upper bytes survive
	task automatic t_dlc();
		logic [31:0] r;
		int k;
		wr(`CRTT_OFS_IRQ_EN, 32'h1);
		can_u.send(2'h0, 2'h1, 4'h8, 64'h8877_6655_4433_2211, 3);
		wait_sig(3, 40, k);
		chk(32'(k != 0), 32'h1, "first frame request");
		can_u.send(2'h0, 2'h1, 4'h2, 64'hF0E1_D2C3_B4A5_9687, 3);
		wait_sig(3, 40, k);
		chk(32'(k), 32'h0, "no request while flag set");
		rd(`CRTT_OFS_BUF_BASE + 12'h008, r);
		chk(r, 32'h4433_9687, "short frame word 0");
		rd(`CRTT_OFS_BUF_BASE + 12'h00C, r);
		chk(r, 32'h8877_6655, "short frame word 1");
		wr(`CRTT_OFS_NF_FLAGS, 32'h1);
		rd(`CRTT_OFS_NF_FLAGS, r);
		chk(r & 32'h7, 32'h0, "flag cleared");
	endtask

	// Wanted counts 4..6, so reload is written one lower
	task automatic t_trig();
		logic [31:0] r;
		int k;
		wr(`CRTT_OFS_CLK_CTRL, 32'h1);
		wr(`CRTT_OFS_TRIG_A, 32'h8000_0001);
		wait_sig(0, 40, k);
		chk(32'(k), 32'h3, "prescaled trigger");
		wr(`CRTT_OFS_CLK_CTRL, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wr(`CRTT_OFS_TRIG_A + 12'(4 * i), 32'h8000_0003 + 32'(i));
			wait_sig(i, 40, k);
			chk(32'(k), 32'h4 + 32'(i), "trigger delay");
			rd(`CRTT_OFS_TRIG_A + 12'(4 * i), r);
			chk(r & 32'hFFFF, 32'h3 + 32'(i), "reload readback");
		end
		wr(`CRTT_OFS_TRIG_A, 32'h0000_0002);
		wait_sig(0, 40, k);
		chk(32'(k), 32'h0, "no start, no trigger");
	endtask

	task automatic t_tout();
		logic [31:0] r;
		int k;
		wr(`CRTT_OFS_IRQ_EN, 32'h0);
		wr(`CRTT_OFS_RX_TIMEOUT, 32'h0001_0000);
		wait_sig(4, 60, k);
		chk(32'(k), 32'h0, "zero reload idle");
		wr(`CRTT_OFS_RX_TIMEOUT, 32'h0001_0014);
		for (int i = 0; i < 6; i++) can_u.send(2'h0, 2'h0, 4'h1, 64'h5A, 8);
		wait_sig(4, 2, k);
		chk(32'(k), 32'h1, "timeout despite frames");
		wr(`CRTT_OFS_IRQ_EN, 32'h1);
		wr(`CRTT_OFS_RX_TIMEOUT, 32'h8001_0014);
		for (int i = 0; i < 6; i++) can_u.send(2'h0, 2'h0, 4'h1, 64'hA5, 8);
		wait_sig(4, 2, k);
		chk(32'(k), 32'h0, "frames hold off timeout");
		wr(`CRTT_OFS_RX_TIMEOUT, 32'h8000_0014);
		wait_sig(4, 50, k);
		chk(32'(k), 32'h0, "request masked");
		rd(`CRTT_OFS_RX_TIMEOUT, r);
		chk(r & 32'h8000_0000, 32'h8000_0000, "flag set while masked");
	endtask

	// Back-to-back frames overrun the writer: the FIFO refuses, then drains
	task automatic t_fill();
		logic [31:0] r;
		int s0;
		s0 = can_u.stalls;
		for (int i = 0; i < 11; i++)
			can_u.send(2'h2, 2'h2, 4'h8, 64'h0123_4567_89AB_CDEF, (i == 10) ? 150 : 0);
		chk(32'(can_u.stalls > s0), 32'h1, "fifo refused when full");
		chk({31'h0, rx_ready}, 32'h1, "fifo drained");
		rd(`CRTT_OFS_BUF_BASE + 12'h010, r);
		chk(r, 32'h89AB_CDEF, "dedicated buffer data");
	endtask

	// Reset, then the scenarios in turn
	initial begin
		errors = 0;
		tests_run = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_dlc();
		t_trig();
		t_tout();
		t_fill();
		end_sim();
	end
endmodule // tb
